// ### common/oag_pkg.sv
package oag_pkg;

  // ****************************************
  // Widths and register file shape
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int BANKS = 4;
  localparam int REGS = 8;
  localparam int PAIRS = 4;

  // ****************************************
  // Register codes within a bank
  // ****************************************
  localparam logic [2:0] OAG_REG_IDX_ONE = 3'h3;
  localparam logic [2:0] OAG_REG_IDX_TWO = 3'h2;
  localparam logic [1:0] OAG_PAIR_PTR_TWO = 2'h2;
  localparam logic [1:0] OAG_PAIR_BASE = 2'h3;

  // ****************************************
  // Reset values and stack region
  // ****************************************
  localparam logic [DATA_W-1:0] OAG_REG_RST = 8'h00;
  localparam logic [ADDR_W-1:0] OAG_SP_RST = 16'hFF00;
  localparam logic [ADDR_W-1:0] OAG_ADDR_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] OAG_HSRAM_LO = 16'hFB00;
  localparam logic [ADDR_W-1:0] OAG_HSRAM_HI = 16'hFEFF;
  localparam logic [ADDR_W-1:0] OAG_ONE = 16'h0001;
  localparam logic [7:0] OAG_ZERO_HI = 8'h00;

  // ****************************************
  // Modes and stack causes
  // ****************************************
  typedef enum logic [1:0] {
    OAG_MODE_INDIRECT,
    OAG_MODE_BASED,
    OAG_MODE_INDEXED,
    OAG_MODE_STACK
  } oag_mode_type;

  typedef enum logic [2:0] {
    OAG_STK_PUSH,
    OAG_STK_POP,
    OAG_STK_CALL,
    OAG_STK_RET,
    OAG_STK_INT_SAVE,
    OAG_STK_INT_RESTORE
  } oag_stack_cause_type;

  function automatic logic oag_in_hsram(input logic [ADDR_W-1:0] a);
    oag_in_hsram = (a >= OAG_HSRAM_LO) && (a <= OAG_HSRAM_HI);
  endfunction : oag_in_hsram

  function automatic logic oag_is_down(input oag_stack_cause_type c);
    oag_is_down = (c == OAG_STK_PUSH) || (c == OAG_STK_CALL) || (c == OAG_STK_INT_SAVE);
  endfunction : oag_is_down

endpackage : oag_pkg

// ### common/oag_rf_if.sv
interface oag_rf_if;
  import oag_pkg::*;
  logic [1:0] rd_bank;
  logic [2:0] rd_code;
  logic [1:0] rd_pair_code;
  logic [DATA_W-1:0] rd_byte;
  logic [ADDR_W-1:0] rd_pair;
  logic [ADDR_W-1:0] base_pair;
  logic [ADDR_W-1:0] ptr_pair;
  logic [DATA_W-1:0] idx_one;
  logic [DATA_W-1:0] idx_two;
  logic wr_en;
  logic [1:0] wr_bank;
  logic [2:0] wr_code;
  logic [DATA_W-1:0] wr_data;
  logic [ADDR_W-1:0] sp;
  logic sp_step;
  logic [ADDR_W-1:0] sp_step_data;
  logic sp_load;
  logic [ADDR_W-1:0] sp_load_data;

  modport core (
    output rd_bank, rd_code, rd_pair_code, wr_en, wr_bank, wr_code, wr_data,
    output sp_step, sp_step_data, sp_load, sp_load_data,
    input rd_byte, rd_pair, base_pair, ptr_pair, idx_one, idx_two, sp
  );
  modport bank (
    input rd_bank, rd_code, rd_pair_code, wr_en, wr_bank, wr_code, wr_data,
    input sp_step, sp_step_data, sp_load, sp_load_data,
    output rd_byte, rd_pair, base_pair, ptr_pair, idx_one, idx_two, sp
  );
endinterface : oag_rf_if

// ### hdl/oag_regbank.sv
module oag_regbank
  import oag_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register file access
  oag_rf_if.bank rf
);

  logic [DATA_W-1:0] regs_reg [BANKS][REGS];
  logic [ADDR_W-1:0] sp_reg;
  logic [ADDR_W-1:0] pair_w [PAIRS];

  // ****************************************
  // Pairs of the active bank
  // ****************************************
  genvar gp;
  generate
    for (gp = 0; gp < PAIRS; gp++) begin : g_pair
      assign pair_w[gp] = {regs_reg[rf.rd_bank][2*gp+1], regs_reg[rf.rd_bank][2*gp]};
    end
  endgenerate

  assign rf.rd_byte = regs_reg[rf.rd_bank][rf.rd_code];
  assign rf.rd_pair = pair_w[rf.rd_pair_code];
  assign rf.base_pair = pair_w[OAG_PAIR_BASE];
  assign rf.ptr_pair = pair_w[OAG_PAIR_PTR_TWO];
  assign rf.idx_one = regs_reg[rf.rd_bank][OAG_REG_IDX_ONE];
  assign rf.idx_two = regs_reg[rf.rd_bank][OAG_REG_IDX_TWO];
  assign rf.sp = sp_reg;

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int b = 0; b < BANKS; b++) begin
        for (int r = 0; r < REGS; r++) begin
          regs_reg[b][r] <= OAG_REG_RST;
        end
      end
    end else if (clk_en && rf.wr_en) begin
      regs_reg[rf.wr_bank][rf.wr_code] <= rf.wr_data;
    end
  end

  // A direct load from the core wins over a stack step in the same cycle
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sp_reg <= OAG_SP_RST;
    end else if (clk_en && rf.sp_load) begin
      sp_reg <= rf.sp_load_data;
    end else if (clk_en && rf.sp_step) begin
      sp_reg <= rf.sp_step_data;
    end
  end

endmodule : oag_regbank

// ### hdl/oag_top.sv
module oag_top
  import oag_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Bank choice
  input wire logic [1:0] bank_select_flags,
  // Address request
  input wire logic req_valid,
  input wire oag_pkg::oag_mode_type req_mode,
  input wire logic ptr_sel_base,
  input wire logic idx_sel_two,
  input wire logic [oag_pkg::DATA_W-1:0] imm_offset,
  input wire oag_pkg::oag_stack_cause_type stack_cause,
  // Register read
  input wire logic [2:0] reg_code,
  input wire logic [1:0] pair_code,
  // Register write
  input wire logic reg_wr_en,
  input wire logic [2:0] reg_wr_code,
  input wire logic [oag_pkg::DATA_W-1:0] reg_wr_data,
  input wire logic sp_load,
  input wire logic [oag_pkg::ADDR_W-1:0] sp_load_data,
  // Address result
  output logic addr_valid,
  output logic [oag_pkg::ADDR_W-1:0] addr_out,
  output logic addr_is_stack,
  output logic stack_fault,
  // Register read result
  output logic [oag_pkg::DATA_W-1:0] reg_rd_data,
  output logic [oag_pkg::ADDR_W-1:0] pair_rd_data,
  output logic [oag_pkg::ADDR_W-1:0] stack_pointer
);
  import oag_pkg::*;

  oag_rf_if rf ();

  oag_regbank u_bank (
    .clk(clk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .rf(rf.bank)
  );

  // ****************************************
  // Register file hookup
  // ****************************************
  wire take = clk_en && req_valid;
  assign rf.rd_bank = bank_select_flags;
  assign rf.rd_code = reg_code;
  assign rf.rd_pair_code = pair_code;
  assign rf.wr_en = reg_wr_en;
  assign rf.wr_bank = bank_select_flags;
  assign rf.wr_code = reg_wr_code;
  assign rf.wr_data = reg_wr_data;
  assign rf.sp_load = sp_load;
  assign rf.sp_load_data = sp_load_data;

  // ****************************************
  // Address forming
  // ****************************************
  // 16-bit sums on purpose: the carry out of bit 15 is lost, so the address wraps
  wire [ADDR_W-1:0] ind_addr = ptr_sel_base ? rf.base_pair : rf.ptr_pair;
  wire [ADDR_W-1:0] based_addr = rf.base_pair + {OAG_ZERO_HI, imm_offset};
  wire [DATA_W-1:0] idx_val = idx_sel_two ? rf.idx_two : rf.idx_one;
  wire [ADDR_W-1:0] indexed_addr = rf.base_pair + {OAG_ZERO_HI, idx_val};
  wire stk_down = oag_is_down(stack_cause);
  wire [ADDR_W-1:0] stk_addr = stk_down ? rf.sp - OAG_ONE : rf.sp;
  wire [ADDR_W-1:0] sp_after = stk_down ? stk_addr : rf.sp + OAG_ONE;
  wire stk_ok = oag_in_hsram(stk_addr);
  wire is_stack = (req_mode == OAG_MODE_STACK);
  wire [ADDR_W-1:0] sel_addr =
    (req_mode == OAG_MODE_INDIRECT) ? ind_addr :
    (req_mode == OAG_MODE_BASED) ? based_addr :
    (req_mode == OAG_MODE_INDEXED) ? indexed_addr : stk_addr;
  wire good = !is_stack || stk_ok;

  // A refused stack access leaves the stack pointer where it was
  assign rf.sp_step = req_valid && is_stack && stk_ok;
  assign rf.sp_step_data = sp_after;

  // ****************************************
  // Output registers
  // ****************************************
  logic addr_valid_reg;
  logic addr_valid_next;
  logic [ADDR_W-1:0] addr_reg;
  logic addr_stack_reg;
  logic stack_fault_reg;
  logic stack_fault_next;
  logic [DATA_W-1:0] reg_data_reg;
  logic [ADDR_W-1:0] pair_data_reg;

  assign addr_valid_next = take && good;
  assign stack_fault_next = take && !good;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_valid_reg <= 1'b0;
      stack_fault_reg <= 1'b0;
    end else if (clk_en) begin
      addr_valid_reg <= addr_valid_next;
      stack_fault_reg <= stack_fault_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      addr_reg <= OAG_ADDR_RST;
      addr_stack_reg <= 1'b0;
    end else if (take && good) begin
      addr_reg <= sel_addr;
      addr_stack_reg <= is_stack;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_data_reg <= OAG_REG_RST;
      pair_data_reg <= OAG_ADDR_RST;
    end else if (clk_en) begin
      reg_data_reg <= rf.rd_byte;
      pair_data_reg <= rf.rd_pair;
    end
  end

  assign addr_valid = addr_valid_reg;
  assign addr_out = addr_reg;
  assign addr_is_stack = addr_stack_reg;
  assign stack_fault = stack_fault_reg;
  assign reg_rd_data = reg_data_reg;
  assign pair_rd_data = pair_data_reg;
  assign stack_pointer = rf.sp;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  a_indirect_addr: assert property (
    take && req_mode == OAG_MODE_INDIRECT |=> addr_valid &&
      addr_out == ($past(ptr_sel_base) ? $past(rf.base_pair) : $past(rf.ptr_pair))
  ) else $error("indirect address not the selected pair");

  a_based_wrap: assert property (
    take && req_mode == OAG_MODE_BASED |=> addr_valid &&
      addr_out == 16'($past(rf.base_pair) + {OAG_ZERO_HI, $past(imm_offset)})
  ) else $error("based address wrong or not wrapped");

  a_indexed_addr: assert property (
    take && req_mode == OAG_MODE_INDEXED |=> addr_valid &&
      addr_out == 16'($past(rf.base_pair) +
        {OAG_ZERO_HI, ($past(idx_sel_two) ? $past(rf.idx_two) : $past(rf.idx_one))})
  ) else $error("indexed address wrong");

  a_stack_region: assert property (
    addr_valid && addr_is_stack |-> oag_in_hsram(addr_out)
  ) else $error("stack access outside high-speed RAM");

  a_stack_fault: assert property (
    take && is_stack && !stk_ok && !sp_load |=> stack_fault && !addr_valid && $stable(rf.sp)
  ) else $error("out-of-region stack access not refused");

  a_stack_push: assert property (
    take && is_stack && stk_ok && stk_down && !sp_load |=>
      rf.sp == 16'($past(rf.sp) - OAG_ONE) && addr_out == rf.sp && addr_is_stack
  ) else $error("push did not predecrement stack pointer");

  a_stack_pop: assert property (
    take && is_stack && stk_ok && !stk_down && !sp_load |=>
      rf.sp == 16'($past(rf.sp) + OAG_ONE) && addr_out == $past(rf.sp)
  ) else $error("pop did not postincrement stack pointer");

  a_pair_bytes: assert property (
    clk_en && reg_code == {pair_code, 1'b0} |=> pair_rd_data[7:0] == reg_rd_data
  ) else $error("pair low byte differs from its register");

  a_bank_write: assert property (
    clk_en && reg_wr_en && !req_valid ##1 clk_en && reg_code == $past(reg_wr_code) &&
      bank_select_flags == $past(bank_select_flags) |=> reg_rd_data == $past(reg_wr_data, 2)
  ) else $error("register not read back from selected bank");

  a_freeze_hold: assert property (
    !clk_en |=> $stable(addr_out) && $stable(rf.sp) && $stable(reg_rd_data)
  ) else $error("state moved while clock enable low");

  c_based_wrap: cover property (take && req_mode == OAG_MODE_BASED && based_addr < rf.base_pair);
  c_indexed: cover property (take && req_mode == OAG_MODE_INDEXED && idx_sel_two);
  c_stack_fault: cover property (take && is_stack && !stk_ok);
  c_push_pop: cover property (take && is_stack && stk_down ##1 take && is_stack && !stk_down);
  c_freeze: cover property (!clk_en && addr_valid);

endmodule : oag_top

// ### dv/oag_mem_path.sv
module oag_mem_path
  import oag_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Address from the generator
  input wire logic addr_valid,
  input wire logic [oag_pkg::ADDR_W-1:0] addr_out,
  // Access tally
  output logic [7:0] access_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Memory path: one byte access per valid pulse
  // ****************************************
  // A pulse stretched past one enabled cycle would be taken as a second access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      access_count <= 8'h00;
    end else if (clk_en && addr_valid) begin
      access_count <= access_count + 8'h01;
    end
  end
endmodule : oag_mem_path

// ### dv/tb_top.sv
module tb_top
  import oag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, reset_n, clk_en, req_valid, ptr_sel_base, idx_sel_two, reg_wr_en, sp_load;
  logic [1:0] bank_select_flags, pair_code;
  logic [2:0] reg_code, reg_wr_code;
  logic [7:0] imm_offset, reg_wr_data, reg_rd_data, access_count;
  logic [15:0] sp_load_data, addr_out, pair_rd_data, stack_pointer, sp;
  logic addr_valid, addr_is_stack, stack_fault;
  oag_mode_type req_mode;
  oag_stack_cause_type stack_cause;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  oag_top dut_u (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
    .bank_select_flags(bank_select_flags), .req_valid(req_valid), .req_mode(req_mode),
    .ptr_sel_base(ptr_sel_base), .idx_sel_two(idx_sel_two), .imm_offset(imm_offset),
    .stack_cause(stack_cause), .reg_code(reg_code), .pair_code(pair_code),
    .reg_wr_en(reg_wr_en), .reg_wr_code(reg_wr_code), .reg_wr_data(reg_wr_data),
    .sp_load(sp_load), .sp_load_data(sp_load_data), .addr_valid(addr_valid),
    .addr_out(addr_out), .addr_is_stack(addr_is_stack), .stack_fault(stack_fault),
    .reg_rd_data(reg_rd_data), .pair_rd_data(pair_rd_data), .stack_pointer(stack_pointer));
  oag_mem_path mem_u (.clk(clk), .reset_n(reset_n), .clk_en(clk_en), .addr_valid(addr_valid),
    .addr_out(addr_out), .access_count(access_count));
  // ****************************************
  // Clock, timeout and checking
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      complete_run();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task chkf(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chkf
  task complete_run();
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run
  // ****************************************
  // Drivers
  // ****************************************
  // Fills regs 7..2 of one bank; pairs are {odd, even}
  task setup_bank(input logic [1:0] b, input logic [47:0] d);
    bank_select_flags = b;
    reg_wr_en = 1'b1;
    for (int k = 0; k < 6; k++) begin
      reg_wr_code = 3'(7 - k);
      reg_wr_data = d[47-8*k -: 8];
      @(posedge clk);
      #5;
    end
    reg_wr_en = 1'b0;
    @(posedge clk);
    #5;
  endtask : setup_bank
  // Request stays raised so that calls run back to back
  task req(input oag_mode_type m, input logic s, input logic [7:0] i, input oag_stack_cause_type c);
    req_valid = 1'b1;
    req_mode = m;
    ptr_sel_base = s;
    idx_sel_two = s;
    imm_offset = i;
    stack_cause = c;
    @(posedge clk);
    #5;
  endtask : req
  task good(input logic [15:0] a, input logic st);
    chkf(addr_valid, 1'b1);
    chkf(stack_fault, 1'b0);
    chk(addr_out, a);
    chkf(addr_is_stack, st);
  endtask : good
  task gap();
    req_valid = 1'b0;
    @(posedge clk);
    #5;
    chkf(addr_valid, 1'b0);
  endtask : gap
  // ****************************************
  // Scenarios
  // ****************************************
  task t_modes();
    bank_select_flags = 2'h1;
    req(OAG_MODE_INDIRECT, 1'b0, 8'h00, OAG_STK_PUSH);
    good(16'h1234, 1'b0);
    req(OAG_MODE_INDIRECT, 1'b1, 8'h00, OAG_STK_PUSH);
    good(16'hFFF8, 1'b0);
    req(OAG_MODE_BASED, 1'b0, 8'h10, OAG_STK_PUSH);
    good(16'h0008, 1'b0);
    req(OAG_MODE_BASED, 1'b0, 8'hFF, OAG_STK_PUSH);
    good(16'h00F7, 1'b0);
    req(OAG_MODE_INDEXED, 1'b0, 8'h00, OAG_STK_PUSH);
    good(16'h00E8, 1'b0);
    req(OAG_MODE_INDEXED, 1'b1, 8'h00, OAG_STK_PUSH);
    good(16'hFFFD, 1'b0);
    bank_select_flags = 2'h2;
    req(OAG_MODE_INDIRECT, 1'b0, 8'h00, OAG_STK_PUSH);
    good(16'hABCD, 1'b0);
    req(OAG_MODE_BASED, 1'b0, 8'h80, OAG_STK_PUSH);
    good(16'h2080, 1'b0);
    gap();
  endtask : t_modes
  task t_stack();
    oag_stack_cause_type c[6];
    logic [15:0] e;
    c = '{OAG_STK_PUSH, OAG_STK_CALL, OAG_STK_RET, OAG_STK_POP, OAG_STK_INT_SAVE,
      OAG_STK_INT_RESTORE};
    sp = OAG_SP_RST;
    for (int k = 0; k < 6; k++) begin
      e = (k == 0 || k == 1 || k == 4) ? sp - 16'h0001 : sp;
      sp = (k == 0 || k == 1 || k == 4) ? sp - 16'h0001 : sp + 16'h0001;
      req(OAG_MODE_STACK, 1'b0, 8'h00, c[k]);
      good(e, 1'b1);
      chk(stack_pointer, sp);
    end
    req(OAG_MODE_STACK, 1'b0, 8'h00, OAG_STK_POP);
    chkf(stack_fault, 1'b1);
    chkf(addr_valid, 1'b0);
    chk(stack_pointer, OAG_SP_RST);
    chk(addr_out, 16'hFEFF);
    req_valid = 1'b0;
    sp_load = 1'b1;
    sp_load_data = OAG_HSRAM_LO;
    @(posedge clk);
    #5;
    sp_load = 1'b0;
    chk(stack_pointer, OAG_HSRAM_LO);
    req(OAG_MODE_STACK, 1'b0, 8'h00, OAG_STK_PUSH);
    chkf(stack_fault, 1'b1);
    chk(stack_pointer, OAG_HSRAM_LO);
    gap();
  endtask : t_stack
  task t_read();
    bank_select_flags = 2'h1;
    reg_code = 3'h3;
    pair_code = OAG_PAIR_BASE;
    @(posedge clk);
    #5;
    chk({8'h00, reg_rd_data}, 16'h00F0);
    chk(pair_rd_data, 16'hFFF8);
    reg_code = 3'h5;
    pair_code = OAG_PAIR_PTR_TWO;
    @(posedge clk);
    #5;
    chk({8'h00, reg_rd_data}, 16'h0012);
    chk(pair_rd_data, 16'h1234);
  endtask : t_read
  // Writes land in the selected bank only and read back one cycle later
  task t_write_read();
    bank_select_flags = 2'h3;
    reg_code = 3'h0;
    pair_code = 2'h0;
    reg_wr_en = 1'b1;
    reg_wr_code = 3'h0;
    reg_wr_data = 8'h5A;
    @(posedge clk);
    #5;
    reg_wr_en = 1'b0;
    @(posedge clk);
    #5;
    chk({8'h00, reg_rd_data}, 16'h005A);
    chk(pair_rd_data, 16'h005A);
    bank_select_flags = 2'h1;
    @(posedge clk);
    #5;
    chk({8'h00, reg_rd_data}, 16'h0000);
  endtask : t_write_read
  // Low clock enable holds the pulse, the address and the read data
  task t_freeze();
    req(OAG_MODE_BASED, 1'b0, 8'h20, OAG_STK_PUSH);
    good(16'h0018, 1'b0);
    clk_en = 1'b0;
    req_mode = OAG_MODE_INDIRECT;
    reg_code = 3'h3;
    repeat (2) @(posedge clk);
    #5;
    chkf(addr_valid, 1'b1);
    chk(addr_out, 16'h0018);
    chk({8'h00, reg_rd_data}, 16'h0000);
    clk_en = 1'b1;
    req_valid = 1'b0;
    @(posedge clk);
    #5;
    chkf(addr_valid, 1'b0);
    chk({8'h00, reg_rd_data}, 16'h00F0);
  endtask : t_freeze
  initial begin
    {reset_n, req_valid, ptr_sel_base, idx_sel_two, reg_wr_en, sp_load} = '0;
    clk_en = 1'b1;
    {bank_select_flags, pair_code, reg_code, reg_wr_code} = '0;
    {imm_offset, reg_wr_data, sp_load_data} = '0;
    req_mode = OAG_MODE_INDIRECT;
    stack_cause = OAG_STK_PUSH;
    repeat (3) @(posedge clk);
    #5;
    reset_n = 1'b1;
    chk(stack_pointer, OAG_SP_RST);
    chk(addr_out, OAG_ADDR_RST);
    setup_bank(2'h1, 48'hFFF8_1234_F005);
    setup_bank(2'h2, 48'h2000_ABCD_0102);
    t_modes();
    t_stack();
    t_read();
    t_write_read();
    t_freeze();
    chk({8'h00, access_count}, 16'h000F);
    complete_run();
  end
endmodule : tb_top
